/* rtl/scs_cfg.svh */
// constants of the serializer control and status plane
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCS_PCLK_MHZ    10
`define SCS_FILT_MIN    3
`define SCS_SYNC_WIN    130
`define SCS_HD_GAP      (`SCS_SYNC_WIN / 2)
`define SCS_PD_HOLD_MS  3
`define SCS_PD_HOLD_CYC (`SCS_PD_HOLD_MS * `SCS_PCLK_MHZ * 1000)
// ----------------------------------------------------------------
// device register offsets, bits and reset values
// ----------------------------------------------------------------
`define SCS_A_PSEL      8'h01
`define SCS_A_CFG       8'h03
`define SCS_A_LINK      8'h0C
`define SCS_A_PCTL      8'h20
`define SCS_A_IEN       8'hC6
`define SCS_A_ISR       8'hC7
`define SCS_B_PICK0     0
`define SCS_B_PICK1     1
`define SCS_B_ADDR2     2
`define SCS_B_MAPOVR    0
`define SCS_B_MAPVAL    1
`define SCS_B_FILT      4
`define SCS_B_LINKDET   0
`define SCS_B_IRQ_ALL   0
`define SCS_B_IRQ_LINK  1
`define SCS_B_IRQ_REM   5
`define SCS_RST_PSEL    8'h01
`define SCS_RST_CFG     8'h10
`define SCS_RST_PCTL    8'h00
`define SCS_RST_IEN     8'h00
// ----------------------------------------------------------------
// host apb offsets and fields
// ----------------------------------------------------------------
`define SCS_APB_CMD     12'h000
`define SCS_APB_STAT    12'h004
`define SCS_APB_LINES   12'h008
`define SCS_CMD_WE      16
`define SCS_CMD_SECOND  17
`define SCS_RST_LINES   32'h0000_0002
`endif

/* rtl/scs_pkg.sv */
// types of the serializer control and status plane
package scs_pkg;
  // host order sequencer
  typedef enum logic [1:0] {SCS_IDLE, SCS_WAIT, SCS_SETTLE} scs_hst_t;

  // glitch filter state
  typedef struct packed {
    logic [1:0] cnt;
    logic       out;
  } scs_filt_t;

  // device state
  typedef struct packed {
    logic [7:0] psel;
    logic [7:0] cfg;
    logic [7:0] pctl0;
    logic [7:0] pctl1;
    logic [7:0] ien;
    logic       rem_pend;
    logic       link_pend;
    logic [1:0] link_q;
    logic       rem_q;
    logic       ack;
    logic [7:0] rdata;
    logic       irq_n;
    logic       mirror_n;
    logic       strap_done;
    logic       strap_map;
    logic       map_sel;
    logic       vs;
  } scs_dev_t;

  // host state
  typedef struct packed {
    scs_hst_t       st;
    logic           auto_rd;
    logic [17:0]    cmd;
    logic           cmd_pend;
    logic [7:0]     rdata;
    logic [7:0]     isr;
    logic [31:0]    lines;
    logic           pd_n;
    logic [14:0]    pd_cnt;
    logic [2:0]     vid;
    logic [2:0][7:0] gap;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
  } scs_host_t;
endpackage

/* rtl/scs_if.sv */
// link between host controller side and serializer control plane
`timescale 1ns/1ps
interface scs_if;
  logic            power_down_n;
  logic            reg_req;
  logic            reg_we;
  logic            reg_second;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic            reg_ack;
  logic [7:0]      reg_rdata;
  logic            horiz_sync;
  logic            vert_sync;
  logic            pixel_valid;
  logic            colour_map_strap;
  logic            remote_irq_in_n;
  logic [1:0]      link_up;
  logic [1:0][6:0] line_fault;
  logic            irq_out_n;
  logic            remote_irq_mirror_n;

  modport dev (
    input  power_down_n, reg_req, reg_we, reg_second, reg_addr, reg_wdata,
    input  horiz_sync, vert_sync, pixel_valid, colour_map_strap,
    input  remote_irq_in_n, link_up, line_fault,
    output reg_ack, reg_rdata, irq_out_n, remote_irq_mirror_n
  );
  modport host (
    output power_down_n, reg_req, reg_we, reg_second, reg_addr, reg_wdata,
    output horiz_sync, vert_sync, pixel_valid, colour_map_strap,
    output remote_irq_in_n, link_up, line_fault,
    input  reg_ack, reg_rdata, irq_out_n, remote_irq_mirror_n
  );
endinterface // scs_if

/* rtl/scs_glitch_filt.sv */
// minimum pulse width filter for one control line
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_glitch_filt
  import scs_pkg::*;
(
  input  wire logic pclk,   // pixel clock
  input  wire logic rst_n,  // async reset
  input  wire logic en,     // filter on
  input  wire logic din,    // raw line
  output logic      dout    // filtered line
);
  scs_filt_t s_reg, s_next;

  // pass a new level once it has stood for the minimum width
  always_comb begin
    s_next = s_reg;
    if (din == s_reg.out) begin
      s_next.cnt = 2'd0;
    end else if (!en || s_reg.cnt == 2'(`SCS_FILT_MIN - 1)) begin
      s_next.out = din;
      s_next.cnt = 2'd0;
    end else begin
      s_next.cnt = s_reg.cnt + 2'd1;
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.out;
endmodule // scs_glitch_filt

/* rtl/scs_device.sv */
// serializer control plane: port steered registers, filter, interrupts
`timescale 1ns/1ps
`include "scs_cfg.svh"
// Operation
// - read returns selected port copy, second wins
// - write updates every selected port copy
// - shared registers ignore port select bits
// - second address reaches second port, ignores picks
// - colour map from strap or register
// - horizontal sync and valid filtered below three clocks
// - source toggles horizontal sync/valid twice per 130 clocks
// - vertical sync toggles once per 130 clocks
// - power down resets all control registers
// - power down held low at least 3 ms
// - link fault shows zero in link detect
// - all cable faults share one status bit
// - active low interrupt from enable/status registers
// - host sets enable bits five and zero
// - remote low input pulls interrupt output low
// - host reads status after seeing interrupt
// - status read clears pending and releases output
// - new remote interrupt only on falling edge
// - mirror follows remote input, needs no clear
// - mirror high while link is down
module scs_device
  import scs_pkg::*;
(
  input  wire logic pclk,            // pixel clock
  input  wire logic presetn,         // async reset, active low
  scs_if.dev        lnk,             // host side link
  output logic      vid_hs,          // filtered horizontal sync
  output logic      vid_vs,          // vertical sync
  output logic      vid_de,          // filtered pixel valid
  output logic      colour_map_sel,  // chosen colour mapping
  output logic [7:0] port0_ctrl,     // first port control copy
  output logic [7:0] port1_ctrl      // second port control copy
);
  scs_dev_t   s_reg, s_next;
  logic       rst_n;
  logic [1:0] link_ok;
  logic [1:0] filt_in;
  logic [1:0] filt_out;
  logic       acc, acc_ok, rd_p1, wr_p0, wr_p1, addr2;
  logic       rem_fall, link_drop, isr_rd;

  // power down acts as reset of every control register
  assign rst_n = presetn & lnk.power_down_n;

  // ----------------------------------------------------------------
  // control line filters
  // ----------------------------------------------------------------
  assign filt_in = {lnk.pixel_valid, lnk.horiz_sync};
  generate
    for (genvar i = 0; i < 2; i++) begin : g_filt
      scs_glitch_filt u_filt (
        .pclk  (pclk),
        .rst_n (rst_n),
        .en    (s_reg.cfg[`SCS_B_FILT]),
        .din   (filt_in[i]),
        .dout  (filt_out[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // link detect per port
  // ----------------------------------------------------------------
  // any cable fault kind collapses into one not-detected bit
  generate
    for (genvar p = 0; p < 2; p++) begin : g_link
      assign link_ok[p] = lnk.link_up[p] & ~(|lnk.line_fault[p]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // access steering
  // ----------------------------------------------------------------
  assign addr2  = s_reg.psel[`SCS_B_ADDR2];
  assign acc    = lnk.reg_req & ~s_reg.ack;
  // second address reads/writes only when enabled, acked either way
  assign acc_ok = acc & (~lnk.reg_second | addr2);
  // second address overrides both pick bits
  assign rd_p1  = addr2 ? lnk.reg_second
                        : s_reg.psel[`SCS_B_PICK1];
  assign wr_p0  = addr2 ? ~lnk.reg_second
                        : s_reg.psel[`SCS_B_PICK0];
  assign wr_p1  = addr2 ? lnk.reg_second
                        : s_reg.psel[`SCS_B_PICK1];

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  // falling edge only, a held low level does not re-arm
  assign rem_fall  = s_reg.rem_q & ~lnk.remote_irq_in_n;
  assign link_drop = |(s_reg.link_q & ~link_ok);
  assign isr_rd    = acc_ok & ~lnk.reg_we & (lnk.reg_addr == `SCS_A_ISR);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next        = s_reg;
    s_next.ack    = acc;
    s_next.rem_q  = lnk.remote_irq_in_n;
    s_next.link_q = link_ok;
    s_next.vs     = lnk.vert_sync;

    // strap caught once, in the first cycle after reset
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.strap_map  = lnk.colour_map_strap;
    end
    s_next.map_sel = s_reg.cfg[`SCS_B_MAPOVR] ? s_reg.cfg[`SCS_B_MAPVAL]
                                              : s_reg.strap_map;

    // register read, shared registers ignore the picks
    s_next.rdata = 8'h00;
    if (acc_ok && !lnk.reg_we) begin
      unique case (lnk.reg_addr)
        `SCS_A_PSEL: s_next.rdata = s_reg.psel;
        `SCS_A_CFG:  s_next.rdata = s_reg.cfg;
        `SCS_A_LINK: s_next.rdata[`SCS_B_LINKDET] =
                       rd_p1 ? link_ok[1] : link_ok[0];
        `SCS_A_PCTL: s_next.rdata = rd_p1 ? s_reg.pctl1
                                          : s_reg.pctl0;
        `SCS_A_IEN:  s_next.rdata = s_reg.ien;
        `SCS_A_ISR: begin
          s_next.rdata[`SCS_B_IRQ_ALL]  = s_reg.rem_pend | s_reg.link_pend;
          s_next.rdata[`SCS_B_IRQ_LINK] = s_reg.link_pend;
          s_next.rdata[`SCS_B_IRQ_REM]  = s_reg.rem_pend;
        end
        default:     s_next.rdata = 8'h00;
      endcase
    end

    // register write
    if (acc_ok && lnk.reg_we) begin
      unique case (lnk.reg_addr)
        `SCS_A_PSEL: s_next.psel = lnk.reg_wdata;
        `SCS_A_CFG:  s_next.cfg  = lnk.reg_wdata;
        `SCS_A_PCTL: begin
          if (wr_p0) begin
            s_next.pctl0 = lnk.reg_wdata;
          end
          if (wr_p1) begin
            s_next.pctl1 = lnk.reg_wdata;
          end
        end
        `SCS_A_IEN:  s_next.ien  = lnk.reg_wdata;
        default:     s_next.ien  = s_reg.ien;
      endcase
    end

    // status read clears, a new event in the same cycle wins
    if (isr_rd) begin
      s_next.rem_pend  = 1'b0;
      s_next.link_pend = 1'b0;
    end
    if (rem_fall && s_reg.ien[`SCS_B_IRQ_REM]) begin
      s_next.rem_pend = 1'b1;
    end
    if (link_drop && s_reg.ien[`SCS_B_IRQ_LINK]) begin
      s_next.link_pend = 1'b1;
    end

    // output drops while enable bit zero is set and a source is pending
    s_next.irq_n = ~(s_reg.ien[`SCS_B_IRQ_ALL] &
                     (s_reg.rem_pend | s_reg.link_pend));

    // mirror follows remote level, forced high without a link
    s_next.mirror_n = (|link_ok) ? lnk.remote_irq_in_n : 1'b1;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.psel     <= `SCS_RST_PSEL;
      s_reg.cfg      <= `SCS_RST_CFG;
      s_reg.pctl0    <= `SCS_RST_PCTL;
      s_reg.pctl1    <= `SCS_RST_PCTL;
      s_reg.ien      <= `SCS_RST_IEN;
      s_reg.rem_q    <= 1'b1;
      s_reg.irq_n    <= 1'b1;
      s_reg.mirror_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lnk.reg_ack             = s_reg.ack;
  assign lnk.reg_rdata           = s_reg.rdata;
  assign lnk.irq_out_n           = s_reg.irq_n;
  assign lnk.remote_irq_mirror_n = s_reg.mirror_n;
  assign vid_hs                  = filt_out[0];
  assign vid_de                  = filt_out[1];
  assign vid_vs                  = s_reg.vs;
  assign colour_map_sel          = s_reg.map_sel;
  assign port0_ctrl              = s_reg.pctl0;
  assign port1_ctrl              = s_reg.pctl1;
endmodule // scs_device

/* rtl/scs_host.sv */
// host end: apb slave driving the serializer control link
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_host
  import scs_pkg::*;
#(
  parameter int PD_HOLD_CYC = `SCS_PD_HOLD_CYC  // power down low hold
)(
  input  wire logic        pclk,     // apb clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic [11:0] paddr,    // apb address
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  scs_if.host              lnk       // device side link
);
  scs_host_t s_reg, s_next;
  logic      setup, mapped;
  logic [7:0] gap_len [3];

  assign setup  = psel & ~penable;
  assign mapped = (paddr == `SCS_APB_CMD) || (paddr == `SCS_APB_STAT) ||
                  (paddr == `SCS_APB_LINES);
  // vertical sync spaced a whole window, others half of it
  assign gap_len[0] = 8'(`SCS_HD_GAP);
  assign gap_len[1] = 8'(`SCS_SYNC_WIN);
  assign gap_len[2] = 8'(`SCS_HD_GAP);

  always_comb begin
    s_next = s_reg;
    // apb: decode in setup, answer in a single access cycle
    if (setup) begin
      s_next.pslverr = !mapped ||
                       (pwrite && paddr == `SCS_APB_CMD && s_reg.cmd_pend);
      s_next.prdata  = 32'h0000_0000;
      if (paddr == `SCS_APB_STAT) begin
        s_next.prdata = {s_reg.isr, 5'h00, (s_reg.pd_n == 1'b0),
                         lnk.remote_irq_mirror_n, lnk.irq_out_n,
                         s_reg.rdata, 7'h00, s_reg.cmd_pend};
      end else if (paddr == `SCS_APB_LINES) begin
        s_next.prdata = s_reg.lines;
      end else if (paddr == `SCS_APB_CMD) begin
        s_next.prdata = {14'h0000, s_reg.cmd};
      end
    end
    if (psel && penable && pwrite && !s_reg.pslverr) begin
      if (paddr == `SCS_APB_CMD) begin
        s_next.cmd      = pwdata[17:0];
        s_next.cmd_pend = 1'b1;
      end else if (paddr == `SCS_APB_LINES) begin
        s_next.lines = pwdata;
      end
    end

    // register order sequencer, status read on interrupt
    unique case (s_reg.st)
      SCS_IDLE: begin
        if (!lnk.irq_out_n && s_reg.pd_n) begin
          s_next.auto_rd = 1'b1;
          s_next.st      = SCS_WAIT;
        end else if (s_reg.cmd_pend && s_reg.pd_n) begin
          s_next.auto_rd = 1'b0;
          s_next.st      = SCS_WAIT;
        end
      end
      SCS_WAIT: begin
        if (lnk.reg_ack) begin
          if (s_reg.auto_rd) begin
            s_next.isr = lnk.reg_rdata;
          end else begin
            s_next.rdata    = lnk.reg_rdata;
            s_next.cmd_pend = 1'b0;
          end
          s_next.st = SCS_SETTLE;
        end
      end
      SCS_SETTLE: s_next.st = SCS_IDLE;
    endcase

    // power down release only after the minimum low time
    if (!s_reg.lines[0]) begin
      s_next.pd_n   = 1'b0;
      s_next.pd_cnt = 15'(PD_HOLD_CYC - 1);
    end else if (!s_reg.pd_n) begin
      if (s_reg.pd_cnt == 15'd0) begin
        s_next.pd_n = 1'b1;
      end else begin
        s_next.pd_cnt = s_reg.pd_cnt - 15'd1;
      end
    end

    // video control lines, each change spaced by its gap
    for (int k = 0; k < 3; k++) begin
      if (s_reg.gap[k] != 8'd0) begin
        s_next.gap[k] = s_reg.gap[k] - 8'd1;
      end else if (s_reg.lines[5 + k] != s_reg.vid[k]) begin
        s_next.vid[k] = s_reg.lines[5 + k];
        s_next.gap[k] = gap_len[k] - 8'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg        <= '0;
      s_reg.st     <= SCS_IDLE;
      s_reg.lines  <= `SCS_RST_LINES;
      s_reg.pd_cnt <= 15'(PD_HOLD_CYC - 1);
      s_reg.pready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // link drive, request held until ack
  assign lnk.reg_req          = (s_reg.st == SCS_WAIT);
  assign lnk.reg_we           = ~s_reg.auto_rd & s_reg.cmd[`SCS_CMD_WE];
  assign lnk.reg_second       = ~s_reg.auto_rd & s_reg.cmd[`SCS_CMD_SECOND];
  assign lnk.reg_addr         = s_reg.auto_rd ? `SCS_A_ISR : s_reg.cmd[7:0];
  assign lnk.reg_wdata        = s_reg.cmd[15:8];
  assign lnk.power_down_n     = s_reg.pd_n;
  assign lnk.remote_irq_in_n  = s_reg.lines[1];
  assign lnk.link_up          = s_reg.lines[3:2];
  assign lnk.colour_map_strap = s_reg.lines[4];
  assign lnk.horiz_sync       = s_reg.vid[0];
  assign lnk.vert_sync        = s_reg.vid[1];
  assign lnk.pixel_valid      = s_reg.vid[2];
  assign lnk.line_fault[0]    = s_reg.lines[14:8];
  assign lnk.line_fault[1]    = s_reg.lines[21:15];
  assign prdata               = s_reg.prdata;
  assign pready               = s_reg.pready;
  assign pslverr              = s_reg.pslverr;
endmodule // scs_host

/* test/scs_link_checker.sv */
// concurrent checks on the host to control plane link
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_link_checker (
  input logic            pclk,                // pixel clock
  input logic            presetn,             // reset, active low
  input logic            power_down_n,        // device enable
  input logic            reg_req,             // order open
  input logic            reg_we,              // order writes
  input logic [7:0]      reg_addr,            // order address
  input logic            reg_ack,             // order answer
  input logic [7:0]      reg_rdata,           // answer data
  input logic            remote_irq_in_n,     // remote request
  input logic [1:0]      link_up,             // port links
  input logic [1:0][6:0] line_fault,          // port faults
  input logic            irq_out_n,           // interrupt out
  input logic            remote_irq_mirror_n  // remote mirror
);
  logic       dev_on;  // device out of reset
  logic       ok;      // some port linked
  logic       rem_q;   // last remote level
  logic       ok_q;    // last link state
  logic [3:0] ev;      // recent interrupt causes
  logic [3:0] clr;     // recent status reads
  // enable and link
  assign dev_on = presetn && power_down_n;
  assign ok = (link_up[0] && !(|line_fault[0]))
           || (link_up[1] && !(|line_fault[1]));
  // cause and clear history
  always_ff @(posedge pclk or negedge dev_on) begin
    if (!dev_on) begin
      rem_q <= 1'b1;
      ok_q  <= 1'b1;
      ev    <= 4'h0;
      clr   <= 4'h0;
    end else begin
      rem_q <= remote_irq_in_n;
      ok_q  <= ok;
      ev    <= {ev[2:0], (rem_q && !remote_irq_in_n) || (ok_q && !ok)};
      clr   <= {clr[2:0], reg_ack && !reg_we && reg_addr == `SCS_A_ISR};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!dev_on);
  // order answers
  a_ack_next: assert property (reg_req && !reg_ack |=> reg_ack)
    else $error("order not answered next cycle");
  a_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("answer held over one cycle");
  a_wr_zero: assert property (reg_ack && reg_we |-> reg_rdata == 8'h00)
    else $error("write answer carries data");
  // power down idles
  a_pd_idle: assert property (disable iff (!presetn)
    !power_down_n |-> irq_out_n && remote_irq_mirror_n && !reg_ack)
    else $error("outputs active in power down");
  // remote mirror
  a_mir_down: assert property (!ok |=> remote_irq_mirror_n)
    else $error("mirror low without link");
  a_mir_follow: assert property (
    ok |=> remote_irq_mirror_n == $past(remote_irq_in_n))
    else $error("mirror not following remote");
  // interrupt output
  a_irq_cause: assert property ($fell(irq_out_n) |-> |ev)
    else $error("interrupt without new cause");
  a_irq_clear: assert property ($rose(irq_out_n) |-> |clr)
    else $error("interrupt released without status read");
endmodule // scs_link_checker

/* test/test_serializer_control_status.sv */
// bench for the serializer control and status plane, both ends
`timescale 1ns/1ps
`include "scs_cfg.svh"
module test_serializer_control_status;
  logic        pclk    = 1'b0;           // pixel clock
  logic        presetn = 1'b0;           // reset, active low
  logic [11:0] paddr   = 12'h000;        // apb address
  logic        psel    = 1'b0;           // apb select
  logic        penable = 1'b0;           // apb enable
  logic        pwrite  = 1'b0;           // apb direction
  logic [31:0] pwdata  = 32'h0000_0000;  // apb write data
  logic [31:0] prdata;                   // apb read data
  logic        pready;                   // apb ready
  logic        pslverr;                  // apb error
  logic [7:0]  port0_ctrl;               // first port copy
  logic [7:0]  port1_ctrl;               // second port copy
  logic        colour_map_sel;           // chosen mapping
  logic [31:0] rd;                       // last apb read
  logic        serr;                     // last apb error
  logic [7:0]  dq;                       // last device read
  logic [31:0] ln;                       // lines image
  logic        vid_hs, vid_vs, vid_de;   // video
  int          err_total   = 0;
  int          checks_done = 0;
  scs_if lnk ();
  scs_host #(.PD_HOLD_CYC(8)) i_scs_host (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .lnk(lnk.host));
  scs_device i_scs_device (.pclk, .presetn, .lnk(lnk.dev), .vid_hs,
    .vid_vs, .vid_de, .colour_map_sel, .port0_ctrl, .port1_ctrl);
  scs_link_checker i_scs_link_checker (.pclk, .presetn,
    .power_down_n(lnk.power_down_n), .reg_req(lnk.reg_req),
    .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr), .reg_ack(lnk.reg_ack),
    .reg_rdata(lnk.reg_rdata), .remote_irq_in_n(lnk.remote_irq_in_n),
    .link_up(lnk.link_up), .line_fault(lnk.line_fault),
    .irq_out_n(lnk.irq_out_n), .remote_irq_mirror_n(lnk.remote_irq_mirror_n));
  // clock
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one counted compare
  task automatic cmp(input logic [7:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // timeout ends the run
  task automatic tmo(input int n, lim);
    if (n >= lim) begin
      err_total++;
      $display("[FAIL] %0t wait ran out", $time);
      final_report;
    end
  endtask
  // one apb transfer
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    tmo(n, 20);
    rd   = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
  endtask
  // one device order
  task automatic ord(input logic s, w, input logic [7:0] a, d);
    int n;
    apb(1'b1, `SCS_APB_CMD, {14'h0000, s, w, d, a});
    for (n = 0; n < 20; n++) begin
      apb(1'b0, `SCS_APB_STAT, 32'h0000_0000);
      if (rd[0] === 1'b0) break;
    end
    tmo(n, 20);
    dq = rd[15:8];
  endtask
  // poll power down
  task automatic pwait(input logic v);
    int n;
    for (n = 0; n < 40; n++) begin
      apb(1'b0, `SCS_APB_STAT, 32'h0000_0000);
      if (rd[18] === v) break;
    end
    tmo(n, 40);
  endtask
  // wait for an irq level
  task automatic wirq(input logic v);
    int n;
    for (n = 0; n < 100; n++) begin
      @(negedge pclk);
      if (lnk.irq_out_n === v) break;
    end
    tmo(n, 100);
    @(posedge pclk);
  endtask
  task automatic t_reset;
    apb(1'b0, `SCS_APB_STAT, 32'h0000_0000);
    cmp({5'h00, rd[18:16]}, 8'h07, "idle after reset");
    apb(1'b0, 12'h00C, 32'h0000_0000);
    cmp({7'h00, serr}, 8'h01, "unmapped apb");
    ln = 32'h0000_000F;
    apb(1'b1, `SCS_APB_LINES, ln);
    pwait(1'b0);
  endtask
  task automatic t_steer;
    ord(0, 1, `SCS_A_PSEL, 8'h01);
    ord(0, 1, `SCS_A_PCTL, 8'hA5);
    cmp(port0_ctrl, 8'hA5, "first only");
    cmp(port1_ctrl, 8'h00, "second untouched");
    ord(0, 1, `SCS_A_PSEL, 8'h03);
    ord(0, 1, `SCS_A_PCTL, 8'h3C);
    cmp(port1_ctrl, 8'h3C, "both written");
    ord(0, 1, `SCS_A_PSEL, 8'h02);
    ord(0, 1, `SCS_A_PCTL, 8'h5A);
    cmp(port0_ctrl, 8'h3C, "first kept");
    ord(0, 1, `SCS_A_PSEL, 8'h03);
    ord(0, 0, `SCS_A_PCTL, 8'h00);
    cmp(dq, 8'h5A, "both picks read second");
    ord(0, 1, `SCS_A_PSEL, 8'h01);
    ord(0, 0, `SCS_A_PCTL, 8'h00);
    cmp(dq, 8'h3C, "first read");
    ord(0, 1, `SCS_A_PSEL, 8'h00);
    ord(0, 0, `SCS_A_CFG, 8'h00);
    cmp(dq, `SCS_RST_CFG, "shared read");
  endtask
  task automatic t_second;
    ord(0, 1, `SCS_A_PSEL, 8'h01);
    ord(1, 1, `SCS_A_PCTL, 8'hEE);
    cmp(port1_ctrl, 8'h5A, "second address off");
    ord(0, 1, `SCS_A_PSEL, 8'h04);
    ord(1, 1, `SCS_A_PCTL, 8'h77);
    ord(0, 1, `SCS_A_PCTL, 8'h11);
    cmp(port1_ctrl, 8'h77, "second address write");
    cmp(port0_ctrl, 8'h11, "primary address write");
    ord(1, 0, `SCS_A_PCTL, 8'h00);
    cmp(dq, 8'h77, "second address read");
    ord(0, 1, `SCS_A_PSEL, 8'h01);
  endtask
  task automatic t_map;
    ord(0, 1, `SCS_A_CFG, 8'h03);
    cmp({7'h00, colour_map_sel}, 8'h01, "map by register");
    apb(1'b1, `SCS_APB_LINES, ln | 32'h0000_00C0);
    @(posedge pclk);
    cmp({6'h00, vid_vs, vid_de}, 8'h03, "filter off");
    ord(0, 1, `SCS_A_CFG, 8'h11);
    cmp({7'h00, colour_map_sel}, 8'h00, "map by register");
    apb(1'b1, `SCS_APB_LINES, ln | 32'h0000_00E0);
    repeat (2) @(posedge pclk);
    cmp({7'h00, vid_hs}, 8'h00, "hs held");
    @(posedge pclk);
    cmp({7'h00, vid_hs}, 8'h01, "hs passed");
  endtask
  task automatic t_fault;
    int k;
    for (k = 0; k < 7; k++) begin
      apb(1'b1, `SCS_APB_LINES, ln | (32'h0000_0100 << k));
      ord(0, 0, `SCS_A_LINK, 8'h00);
      cmp({7'h00, dq[0]}, 8'h00, "fault hides link");
    end
    apb(1'b1, `SCS_APB_LINES, ln);
    ord(0, 0, `SCS_A_LINK, 8'h00);
    cmp({7'h00, dq[0]}, 8'h01, "link detected");
  endtask
  task automatic t_irq;
    ord(0, 1, `SCS_A_IEN, 8'h21);
    ln[1] = 1'b0;
    apb(1'b1, `SCS_APB_LINES, ln);
    wirq(1'b0);
    wirq(1'b1);
    apb(1'b0, `SCS_APB_STAT, 32'h0000_0000);
    cmp(rd[31:24], 8'h21, "status read");
    repeat (20) @(posedge pclk);
    cmp({7'h00, lnk.irq_out_n}, 8'h01, "held level ignored");
    cmp({7'h00, lnk.remote_irq_mirror_n}, 8'h00, "mirror low");
    ln[1] = 1'b1;
    apb(1'b1, `SCS_APB_LINES, ln);
    cmp({7'h00, lnk.remote_irq_mirror_n}, 8'h01, "mirror high");
    ln[1] = 1'b0;
    apb(1'b1, `SCS_APB_LINES, ln);
    wirq(1'b0);
    wirq(1'b1);
    ln[3:2] = 2'b00;
    apb(1'b1, `SCS_APB_LINES, ln);
    cmp({7'h00, lnk.remote_irq_mirror_n}, 8'h01, "mirror unlinked");
  endtask
  task automatic t_pdown;
    ln = 32'h0000_001E;
    apb(1'b1, `SCS_APB_LINES, ln);
    pwait(1'b1);
    cmp(port0_ctrl, 8'h00, "copy cleared");
    ln[0] = 1'b1;
    apb(1'b1, `SCS_APB_LINES, ln);
    pwait(1'b0);
    cmp({7'h00, colour_map_sel}, 8'h01, "map by strap");
    ord(0, 0, `SCS_A_IEN, 8'h00);
    cmp(dq, `SCS_RST_IEN, "enable default");
    ord(0, 0, `SCS_A_PSEL, 8'h00);
    cmp(dq, `SCS_RST_PSEL, "select default");
    ord(0, 0, `SCS_A_CFG, 8'h00);
    cmp(dq, `SCS_RST_CFG, "config default");
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_steer;
    t_second;
    t_map;
    t_fault;
    t_irq;
    t_pdown;
    final_report;
  end
endmodule // test_serializer_control_status
